/* File: pef_pkg.sv */
`default_nettype none
package pef_pkg;
    // ==========================================================
    // bus and widths
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          TMR_W_DEF    = 16;
    localparam int          NUM_CH       = 4;
    localparam int          NUM_LOOPS    = 6;
    // ==========================================================
    // register offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_ECHO_DUR = 8'h04;
    localparam logic [7:0]  OFS_LOCK_DUR = 8'h08;
    localparam logic [7:0]  OFS_PRIO_DUR = 8'h0C;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;
    // ==========================================================
    // field layout
    localparam int          CTRL_W       = 5;
    localparam int          CTRL_SCH_LSB = 0;
    localparam int          CTRL_CH_LSB  = 2;
    localparam int          CTRL_GDOC    = 4;
    localparam int          STAT_ST_LSB  = 0;
    localparam int          STAT_ECHO    = 2;
    localparam int          STAT_ACC     = 3;
    localparam int          STAT_T3P     = 4;
    localparam int          STAT_VOID    = 5;
    localparam int          STAT_FT_LSB  = 8;
    // ==========================================================
    // reset values; priority delay defaults to zero
    localparam logic [4:0]  RST_CTRL     = 5'h01;
    localparam logic [15:0] RST_ECHO_DUR = 16'h000A;
    localparam logic [15:0] RST_LOCK_DUR = 16'h0064;
    localparam logic [15:0] RST_PRIO_DUR = 16'h0000;
    // ==========================================================
    // zone loop positions
    localparam int          LP_AG        = 0;
    localparam int          LP_BG        = 1;
    localparam int          LP_CG        = 2;
    localparam int          LP_AB        = 3;
    localparam int          LP_BC        = 4;
    localparam int          LP_CA        = 5;
    // ==========================================================
    // echo codes
    localparam logic [3:0]  ECHO2_AG     = 4'h1;
    localparam logic [3:0]  ECHO2_BG     = 4'h2;
    localparam logic [3:0]  ECHO2_CG     = 4'h3;
    localparam logic [3:0]  ECHO4_AG     = 4'h1;
    localparam logic [3:0]  ECHO4_BG     = 4'h2;
    localparam logic [3:0]  ECHO4_CG     = 4'h4;
    localparam logic [3:0]  MASK_ONE     = 4'h1;
    localparam logic [3:0]  MASK_TWO     = 4'h3;
    localparam logic [3:0]  MASK_FOUR    = 4'hF;
    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {SCH_UNDER, SCH_OVER, SCH_HYB, SCH_DCUB} pef_scheme_t;
    typedef enum logic [1:0] {CH_ONE, CH_TWO, CH_FOUR, CH_RSVD} pef_chan_t;
    typedef enum logic [1:0] {ES_IDLE, ES_PULSE, ES_LOCK} pef_echo_st_t;
    typedef enum logic [3:0] {
        FT_AG, FT_BG, FT_CG, FT_AB, FT_ABG, FT_BC, FT_BCG,
        FT_CA, FT_CAG, FT_3P, FT_UNREC
    } pef_fault_t;
endpackage : pef_pkg
`default_nettype wire

/* File: pef_psel_if.sv */
`default_nettype none
interface pef_psel_if;
    import pef_pkg::*;
    pef_fault_t                 ps_type;
    logic                       ps_void;
    logic [NUM_LOOPS-1:0]       z1_loops;
    logic [NUM_LOOPS-1:0]       z2_loops;
    pef_scheme_t                scheme;
    pef_fault_t                 res_type;
    logic                       res_void;
    modport resolver (input ps_type, ps_void, z1_loops, z2_loops, scheme,
                      output res_type, res_void);
    modport user (output ps_type, ps_void, z1_loops, z2_loops, scheme,
                  input res_type, res_void);
endinterface : pef_psel_if
`default_nettype wire

/* File: pef_fault_resolve.sv */
`default_nettype none
module pef_fault_resolve (
    pef_psel_if.resolver        psel
);
    import pef_pkg::*;

    // ==========================================================
    // fault type from the six loops of one zone
    function automatic pef_fault_t pef_decode_loops(input logic [NUM_LOOPS-1:0] lp);
        logic [2:0] g;
        logic [2:0] p;
        g = {lp[LP_CG], lp[LP_BG], lp[LP_AG]};
        p = {lp[LP_CA], lp[LP_BC], lp[LP_AB]};
        pef_decode_loops = FT_UNREC;
        if (p == 3'b111) begin
            pef_decode_loops = FT_3P;
        end else if (p == 3'b000) begin
            case (g)
                3'b001:  pef_decode_loops = FT_AG;
                3'b010:  pef_decode_loops = FT_BG;
                3'b100:  pef_decode_loops = FT_CG;
                3'b011:  pef_decode_loops = FT_ABG;
                3'b110:  pef_decode_loops = FT_BCG;
                3'b101:  pef_decode_loops = FT_CAG;
                3'b111:  pef_decode_loops = FT_3P;
                default: pef_decode_loops = FT_UNREC;
            endcase
        end else begin
            // a ground loop outside the phase pair cannot form one pattern
            case ({p, g})
                6'b001_000: pef_decode_loops = FT_AB;
                6'b001_011: pef_decode_loops = FT_ABG;
                6'b010_000: pef_decode_loops = FT_BC;
                6'b010_110: pef_decode_loops = FT_BCG;
                6'b100_000: pef_decode_loops = FT_CA;
                6'b100_101: pef_decode_loops = FT_CAG;
                default:    pef_decode_loops = FT_UNREC;
            endcase
        end
    endfunction : pef_decode_loops

    // ==========================================================
    // invalid flag and zone fallback
    logic [NUM_LOOPS-1:0] zone;

    always_comb begin
        psel.res_void = psel.ps_void || (psel.ps_type == FT_UNREC);
        zone = (psel.scheme == SCH_UNDER) ? psel.z1_loops : psel.z2_loops;
        psel.res_type = psel.res_void ? pef_decode_loops(zone) : psel.ps_type;
    end
endmodule : pef_fault_resolve
`default_nettype wire

/* File: pef_echo_select.sv */
// Operation
// - permissive overreach mode echoes a reliable received permissive when line end open
// - hybrid mode also needs no reverse call from zone 4 or ground directional
// - echo is one pulse, then lockout for a programmed interval
// - pulse length is programmed, independent of received input shape
// - any operated overreaching element suppresses the echo
// - echo exists only in overreach, hybrid and unblocking schemes
// - one-bit channel echoes receive bit one on transmit bit one
// - two-bit channel: AG 1,0; BG 0,1; CG 1,1; else as received
// - four-bit channel: AG bit one, BG bit two, CG bit three; else as received
// - invalid-fault flag raised when no single valid fault pattern fits
// - invalid flag with a local trip request gives a three-pole trip
// - invalid flag: underreach transfer uses zone 1, others zone 2
// - zone fallback examines all six fault loops
// - priority timer holds off local trip acceptance for its interval
`default_nettype none
module pef_echo_select #(
    parameter int TMR_W = pef_pkg::TMR_W_DEF
) (
    input  wire logic                           core_clk,
    input  wire logic                           reset_n,
    input  wire logic [pef_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [pef_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [pef_pkg::DATA_W-1:0]     reg_rdata_r,
    input  wire logic [pef_pkg::NUM_CH-1:0]     receive_bits,
    input  wire logic [pef_pkg::NUM_CH-1:0]     guard_loss,
    input  wire logic                           line_open,
    input  wire logic                           overreach_op,
    input  wire logic                           z4_reverse,
    input  wire logic                           gdoc_reverse,
    input  wire pef_pkg::pef_fault_t            ps_type,
    input  wire logic                           ps_void,
    input  wire logic [pef_pkg::NUM_LOOPS-1:0]  z1_loops,
    input  wire logic [pef_pkg::NUM_LOOPS-1:0]  z2_loops,
    input  wire logic                           local_trip_req,
    output logic      [pef_pkg::NUM_CH-1:0]     transmit_bits_r,
    output logic                                echo_active_r,
    output logic                                fault_void_r,
    output pef_pkg::pef_fault_t                 fault_type_r,
    output logic                                trip_accept_r,
    output logic                                trip_3p_r
);
    import pef_pkg::*;

    // ==========================================================
    // parameter check
    if (TMR_W < 1 || TMR_W > DATA_W) begin : g_bad_tmr
        $error("TMR_W must lie between 1 and the data width");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [CTRL_W-1:0]  ctrl;
        logic [TMR_W-1:0]   echo_dur;
        logic [TMR_W-1:0]   lock_dur;
        logic [TMR_W-1:0]   prio_dur;
        pef_echo_st_t       st;
        logic [TMR_W-1:0]   cnt;
        logic [TMR_W-1:0]   pcnt;
        logic [NUM_CH-1:0]  tx;
        logic               echo;
        logic               vd;
        pef_fault_t         ft;
        logic               acc;
        logic               t3p;
        logic [DATA_W-1:0]  rdata;
    } pef_state_t;

    pef_state_t s_r;
    pef_state_t s_nxt;

    pef_psel_if psel ();

    pef_fault_resolve u_resolve (
        .psel (psel.resolver)
    );

    pef_scheme_t        scheme;
    pef_chan_t          chan;
    logic               gdoc_en;
    logic [NUM_CH-1:0]  ch_mask;
    logic [NUM_CH-1:0]  rx_eff;
    logic               hybrid_like;
    logic               echo_ok;
    logic               rev_fault;

    assign scheme  = pef_scheme_t'(s_r.ctrl[CTRL_SCH_LSB +: 2]);
    assign chan    = pef_chan_t'(s_r.ctrl[CTRL_CH_LSB +: 2]);
    assign gdoc_en = s_r.ctrl[CTRL_GDOC];

    assign psel.ps_type  = ps_type;
    assign psel.ps_void  = ps_void;
    assign psel.z1_loops = z1_loops;
    assign psel.z2_loops = z2_loops;
    assign psel.scheme   = scheme;

    // ==========================================================
    // echo pattern by channel width and local fault type
    function automatic logic [NUM_CH-1:0] pef_echo_code(
        input pef_chan_t ch, input pef_fault_t ft, input logic [NUM_CH-1:0] rxv);
        pef_echo_code = rxv;
        case (ch)
            CH_ONE: pef_echo_code = rxv & MASK_ONE;
            CH_TWO: begin
                case (ft)
                    FT_AG:   pef_echo_code = ECHO2_AG;
                    FT_BG:   pef_echo_code = ECHO2_BG;
                    FT_CG:   pef_echo_code = ECHO2_CG;
                    default: pef_echo_code = rxv & MASK_TWO;
                endcase
            end
            CH_FOUR: begin
                case (ft)
                    FT_AG:   pef_echo_code = ECHO4_AG;
                    FT_BG:   pef_echo_code = ECHO4_BG;
                    FT_CG:   pef_echo_code = ECHO4_CG;
                    default: pef_echo_code = rxv & MASK_FOUR;
                endcase
            end
            default: pef_echo_code = '0;
        endcase
    endfunction : pef_echo_code

    // ==========================================================
    // echo qualification
    always_comb begin
        case (chan)
            CH_ONE:  ch_mask = MASK_ONE;
            CH_TWO:  ch_mask = MASK_TWO;
            CH_FOUR: ch_mask = MASK_FOUR;
            default: ch_mask = '0;
        endcase
        // unblocking needs guard loss beside the receive bit
        rx_eff = (scheme == SCH_DCUB) ? (receive_bits & guard_loss & ch_mask)
                                      : (receive_bits & ch_mask);
        hybrid_like = (scheme == SCH_HYB) || (scheme == SCH_DCUB);
        rev_fault = z4_reverse || (gdoc_en && gdoc_reverse);
        echo_ok = (scheme != SCH_UNDER)
               && line_open && (rx_eff != '0)
               && !overreach_op
               && !(hybrid_like && rev_fault);
    end

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = '0;

        // register port
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL:     s_nxt.ctrl     = reg_wdata[CTRL_W-1:0];
                OFS_ECHO_DUR: s_nxt.echo_dur = reg_wdata[TMR_W-1:0];
                OFS_LOCK_DUR: s_nxt.lock_dur = reg_wdata[TMR_W-1:0];
                OFS_PRIO_DUR: s_nxt.prio_dur = reg_wdata[TMR_W-1:0];
                default:      s_nxt.ctrl     = s_r.ctrl;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:     s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
                OFS_ECHO_DUR: s_nxt.rdata[TMR_W-1:0]  = s_r.echo_dur;
                OFS_LOCK_DUR: s_nxt.rdata[TMR_W-1:0]  = s_r.lock_dur;
                OFS_PRIO_DUR: s_nxt.rdata[TMR_W-1:0]  = s_r.prio_dur;
                OFS_STATUS: begin
                    s_nxt.rdata[STAT_ST_LSB +: 2] = s_r.st;
                    s_nxt.rdata[STAT_ECHO]        = s_r.echo;
                    s_nxt.rdata[STAT_ACC]         = s_r.acc;
                    s_nxt.rdata[STAT_T3P]         = s_r.t3p;
                    s_nxt.rdata[STAT_VOID]        = s_r.vd;
                    s_nxt.rdata[STAT_FT_LSB +: 4] = s_r.ft;
                end
                default:      s_nxt.rdata = '0;
            endcase
        end

        // fault type, refreshed every cycle
        s_nxt.vd = psel.res_void;
        s_nxt.ft = psel.res_type;

        // echo one-shot; a zero setting still gives one cycle
        case (s_r.st)
            ES_IDLE: begin
                if (echo_ok) begin
                    s_nxt.st   = ES_PULSE;
                    s_nxt.cnt  = TMR_W'(1);
                    s_nxt.echo = 1'b1;
                    s_nxt.tx   = pef_echo_code(chan, psel.res_type, rx_eff);
                end
            end
            ES_PULSE: begin
                // length from the setting, cut short by overreach_op; receive bits are not looked at
                if (overreach_op || s_r.cnt >= s_r.echo_dur) begin
                    s_nxt.st   = ES_LOCK;
                    s_nxt.cnt  = TMR_W'(1);
                    s_nxt.echo = 1'b0;
                    s_nxt.tx   = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + TMR_W'(1);
                end
            end
            ES_LOCK: begin
                if (s_r.cnt >= s_r.lock_dur) begin
                    s_nxt.st  = ES_IDLE;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + TMR_W'(1);
                end
            end
            default: begin
                s_nxt.st   = ES_IDLE;
                s_nxt.cnt  = '0;
                s_nxt.echo = 1'b0;
                s_nxt.tx   = '0;
            end
        endcase

        // pilot priority hold-off on local trips
        if (!local_trip_req) begin
            s_nxt.pcnt = '0;
            s_nxt.acc  = 1'b0;
        end else if (s_r.pcnt >= s_r.prio_dur) begin
            s_nxt.acc = 1'b1;
        end else begin
            s_nxt.pcnt = s_r.pcnt + TMR_W'(1);
        end
        s_nxt.t3p = s_nxt.acc && psel.res_void;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r          <= '0;
            s_r.ctrl     <= RST_CTRL;
            s_r.echo_dur <= TMR_W'(RST_ECHO_DUR);
            s_r.lock_dur <= TMR_W'(RST_LOCK_DUR);
            s_r.prio_dur <= TMR_W'(RST_PRIO_DUR);
            s_r.st       <= ES_IDLE;
            s_r.ft       <= FT_UNREC;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata_r     = s_r.rdata;
    assign transmit_bits_r = s_r.tx;
    assign echo_active_r   = s_r.echo;
    assign fault_void_r    = s_r.vd;
    assign fault_type_r    = s_r.ft;
    assign trip_accept_r   = s_r.acc;
    assign trip_3p_r       = s_r.t3p;

    // ==========================================================
    // checks
    logic [TMR_W-1:0] act_len;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            act_len <= '0;
        end else begin
            act_len <= s_nxt.echo ? act_len + TMR_W'(1) : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_echo_needs_open: assert property ($rose(echo_active_r) |-> $past(line_open))
        else $error("echo started without line end open");

    a_hyb_rev_block: assert property (s_r.st == ES_IDLE && hybrid_like && z4_reverse
        |=> !$rose(echo_active_r))
        else $error("echo despite reverse fault");

    a_lock_after_pulse: assert property ($fell(echo_active_r)
        |-> s_r.st == ES_LOCK ##1 !echo_active_r)
        else $error("pulse not followed by lockout");

    a_lock_quiet: assert property (s_r.st == ES_LOCK
        |-> !echo_active_r && transmit_bits_r == '0)
        else $error("echo output during lockout");

    a_pulse_len_max: assert property (echo_active_r
        |-> act_len <= ((s_r.echo_dur == '0) ? TMR_W'(1) : s_r.echo_dur))
        else $error("echo pulse longer than setting");

    a_overreach_kill: assert property (overreach_op |=> !echo_active_r)
        else $error("echo while overreaching element operated");

    a_no_echo_under: assert property (scheme == SCH_UNDER && s_r.st == ES_IDLE
        |=> !echo_active_r)
        else $error("echo in underreach transfer scheme");

    a_one_bit_echo: assert property ($rose(echo_active_r) && $past(chan) == CH_ONE
        |-> transmit_bits_r == $past(rx_eff & MASK_ONE))
        else $error("one bit echo differs from receive bit one");

    a_two_bit_ag: assert property ($rose(echo_active_r) && $past(chan) == CH_TWO
        && $past(psel.res_type) == FT_AG |-> transmit_bits_r == ECHO2_AG)
        else $error("two bit AG echo wrong");

    a_two_bit_cg: assert property ($rose(echo_active_r) && $past(chan) == CH_TWO
        && $past(psel.res_type) == FT_CG |-> transmit_bits_r == ECHO2_CG)
        else $error("two bit CG echo wrong");

    a_four_bit_ag: assert property ($rose(echo_active_r) && $past(chan) == CH_FOUR
        && $past(psel.res_type) == FT_AG |-> transmit_bits_r == ECHO4_AG)
        else $error("four bit AG echo wrong");

    a_four_bit_bg: assert property ($rose(echo_active_r) && $past(chan) == CH_FOUR
        && $past(psel.res_type) == FT_BG |-> transmit_bits_r == ECHO4_BG)
        else $error("four bit BG echo wrong");

    a_four_bit_cg: assert property ($rose(echo_active_r) && $past(chan) == CH_FOUR
        && $past(psel.res_type) == FT_CG |-> transmit_bits_r == ECHO4_CG)
        else $error("four bit CG echo wrong");

    a_unblock_guard: assert property ($rose(echo_active_r)
        && $past(scheme) == SCH_DCUB |-> $past((receive_bits & guard_loss) != '0))
        else $error("unblocking echo without guard loss");

    a_void_flag: assert property (ps_void || ps_type == FT_UNREC
        |=> fault_void_r)
        else $error("invalid fault flag not raised");

    a_three_pole: assert property (local_trip_req && psel.res_void && trip_accept_r
        |=> trip_3p_r || !$past(local_trip_req, 1))
        else $error("invalid fault trip not three pole");

    a_zone1_under: assert property (ps_void && scheme == SCH_UNDER
        && z1_loops == NUM_LOOPS'(1 << LP_BG) |=> fault_type_r == FT_BG)
        else $error("zone 1 fallback wrong");

    a_zone2_other: assert property (ps_void && scheme != SCH_UNDER
        && z2_loops == NUM_LOOPS'(1 << LP_AG) |=> fault_type_r == FT_AG)
        else $error("zone 2 fallback wrong");

    a_prio_hold: assert property (local_trip_req && !trip_accept_r
        && s_r.pcnt < s_r.prio_dur |=> !trip_accept_r)
        else $error("local trip accepted before priority time");

    a_accept_zero: assert property (local_trip_req && s_r.prio_dur == '0
        |=> trip_accept_r)
        else $error("local trip held with zero priority time");
endmodule : pef_echo_select
`default_nettype wire

/* File: pef_remote_term.sv */
`default_nettype none
module pef_remote_term (
    input  wire logic       core_clk,
    input  wire logic [3:0] key_bits,
    input  wire logic [3:0] guard_gone,
    output var  logic [3:0] receive_bits,
    output var  logic [3:0] guard_loss
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // channel delay of one clock; remote keys levels, not pulses
    always @(posedge core_clk) begin
        receive_bits <= key_bits;
        guard_loss   <= guard_gone;
    end
endmodule : pef_remote_term
`default_nettype wire

/* File: tb_pilot_echo_fault_select.sv */
`default_nettype none
module tb_pilot_echo_fault_select import pef_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ECHO_D = 2;
    localparam int LOCK_D = 3;
    logic        core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        line_open = 1'b0, overreach_op = 1'b0, z4_reverse = 1'b0;
    logic        gdoc_reverse = 1'b0, ps_void = 1'b0, local_trip_req = 1'b0;
    logic        echo_active_r, fault_void_r, trip_accept_r, trip_3p_r;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_r;
    logic [3:0]  key_bits = 4'h0, guard_gone = 4'h0, receive_bits, guard_loss, transmit_bits_r;
    logic [5:0]  z1_loops = 6'h00, z2_loops = 6'h00;
    pef_fault_t  ps_type = FT_AG, fault_type_r;
    int          failures = 0, tests_run = 0, cyc = 0;
    // ==========================================
    // echo table: one-bit masks to bit one, multi-phase returns what came in
    logic [4:0]  tc [9] = '{5'h01, 5'h05, 5'h05, 5'h05, 5'h05, 5'h09, 5'h09, 5'h09, 5'h09};
    pef_fault_t  tf [9] = '{FT_AG, FT_AG, FT_BG, FT_CG, FT_AB, FT_AG, FT_BG, FT_CG, FT_BC};
    logic [3:0]  tr [9] = '{4'h3, 4'h3, 4'h3, 4'h1, 4'h2, 4'hF, 4'hF, 4'hF, 4'h5};
    logic [3:0]  te [9] = '{4'h1, ECHO2_AG, ECHO2_BG, ECHO2_CG, 4'h2,
                            ECHO4_AG, ECHO4_BG, ECHO4_CG, 4'h5};

    always #50 core_clk = ~core_clk;

    pef_echo_select dut_u (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_r, .receive_bits, .guard_loss, .line_open, .overreach_op, .z4_reverse,
        .gdoc_reverse, .ps_type, .ps_void, .z1_loops, .z2_loops, .local_trip_req,
        .transmit_bits_r, .echo_active_r, .fault_void_r, .fault_type_r, .trip_accept_r,
        .trip_3p_r);
    pef_remote_term far_u (.core_clk, .key_bits, .guard_gone, .receive_bits, .guard_loss);
    // ==========================================
    // tasks
    task automatic conclude;
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk("read data", e, reg_rdata_r);
    endtask : rd
    task automatic setin(input logic [4:0] c, input pef_fault_t f, input logic [3:0] r, g);
        wr(OFS_CTRL, 32'(c));
        ps_type    <= f;
        key_bits   <= r;
        guard_gone <= g;
    endtask : setin
    task automatic echo_run(input logic [3:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        line_open <= 1'b1;
        while (echo_active_r !== 1'b1 && n < 6) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("echo bits", 32'(e), 32'(transmit_bits_r));
        n = 0;
        while (echo_active_r === 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("echo length", ECHO_D, 32'(n));
        repeat (LOCK_D - 1) begin
            chk("lockout", 0, {echo_active_r, transmit_bits_r});
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        line_open <= 1'b0;
        repeat (LOCK_D + 4) @(posedge core_clk);
    endtask : echo_run
    task automatic echo_none;
        @(posedge core_clk);
        line_open <= 1'b1;
        repeat (5) begin
            @(posedge core_clk);
            #1;
            chk("no echo", 0, {echo_active_r, transmit_bits_r});
        end
        @(posedge core_clk);
        line_open <= 1'b0;
    endtask : echo_none
    task automatic fres(input logic [4:0] c, input logic [5:0] l1, l2, input pef_fault_t e);
        wr(OFS_CTRL, 32'(c));
        z1_loops <= l1;
        z2_loops <= l2;
        repeat (2) @(posedge core_clk);
        #1;
        chk("fault type", 32'(e), 32'(fault_type_r));
        chk("fault void", 1, 32'(fault_void_r));
    endtask : fres
    task automatic trip_run(input int p, input logic e3);
        int n;
        n = 0;
        wr(OFS_PRIO_DUR, 32'(p));
        @(posedge core_clk);
        local_trip_req <= 1'b1;
        while (trip_accept_r !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("accept delay", 32'(p + 1), 32'(n));
        chk("three pole", 32'(e3), 32'(trip_3p_r));
        @(posedge core_clk);
        local_trip_req <= 1'b0;
    endtask : trip_run
    // ==========================================
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(OFS_CTRL, 32'(RST_CTRL));
        rd(OFS_ECHO_DUR, 32'(RST_ECHO_DUR));
        rd(OFS_LOCK_DUR, 32'(RST_LOCK_DUR));
        rd(OFS_PRIO_DUR, 32'(RST_PRIO_DUR));
        rd(8'h14, 32'h0);
        wr(OFS_ECHO_DUR, ECHO_D);
        wr(OFS_LOCK_DUR, LOCK_D);
        for (int k = 0; k < 9; k++) begin
            setin(tc[k], tf[k], tr[k], 4'h0);
            echo_run(te[k]);
        end
        setin(5'h01, FT_AG, 4'h1, 4'h0);
        overreach_op <= 1'b1;
        echo_none();
        overreach_op <= 1'b0;
        setin(5'h00, FT_AG, 4'h1, 4'h0);
        echo_none();
        setin(5'h02, FT_AG, 4'h1, 4'h0);
        z4_reverse <= 1'b1;
        echo_none();
        z4_reverse <= 1'b0;
        setin(5'h12, FT_AG, 4'h1, 4'h0);
        gdoc_reverse <= 1'b1;
        echo_none();
        setin(5'h02, FT_AG, 4'h1, 4'h0);
        echo_run(4'h1);
        gdoc_reverse <= 1'b0;
        setin(5'h0B, FT_AB, 4'hF, 4'h0);
        echo_none();
        setin(5'h0B, FT_AB, 4'hB, 4'h6);
        echo_run(4'h2);
        ps_void <= 1'b1;
        fres(5'h01, 6'h02, 6'h01, FT_AG);
        fres(5'h00, 6'h02, 6'h01, FT_BG);
        fres(5'h01, 6'h00, 6'h10, FT_BC);
        fres(5'h01, 6'h00, 6'h16, FT_BCG);
        ps_void <= 1'b0;
        ps_type <= FT_UNREC;
        fres(5'h01, 6'h00, 6'h00, FT_UNREC);
        trip_run(3, 1'b1);
        rd(OFS_STATUS, 32'h0000_0A20);
        ps_type <= FT_AG;
        repeat (2) @(posedge core_clk);
        trip_run(0, 1'b0);
        conclude();
    end
endmodule : tb_pilot_echo_fault_select
`default_nettype wire
